// >>> design/bcs_consts.svh
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------------
`define BCS_OFS_COMMAND     4'h0
`define BCS_OFS_RESULT      4'h1
`define BCS_OFS_POINTER     4'h2
`define BCS_OFS_COUNTER     4'h3
`define BCS_OFS_FLAGS       4'h4
`define BCS_OFS_STATUS      4'h5

// ----------------------------------------------------------------------------
// Opcode bytes
// ----------------------------------------------------------------------------
`define BCS_OP_PREFIX       8'hed
`define BCS_OP_DOWN_ONCE    8'ha9
`define BCS_OP_DOWN_REPEAT  8'hb9
`define BCS_OP_UP_ONCE      8'ha1
`define BCS_OP_UP_REPEAT    8'hb1

// ----------------------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------------------
`define BCS_FLG_NEG         7
`define BCS_FLG_EQUAL       6
`define BCS_FLG_NIBBLE      4
`define BCS_FLG_NONZERO     2
`define BCS_FLG_SUB         1
`define BCS_FLG_BORROW      0

// ----------------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------------
`define BCS_ST_BUSY         0
`define BCS_ST_DONE         1
`define BCS_ST_INTERRUPTED  2
`define BCS_ST_BAD_OPCODE   3

// ----------------------------------------------------------------------------
// Clock states per phase (one clock state is one core clock)
// ----------------------------------------------------------------------------
`define BCS_FETCH_T         4'd6
`define BCS_READ_T          4'd3
`define BCS_INT_LAST_T      4'd3
`define BCS_INT_CONT_T      4'd5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BCS_RST_BYTE        8'h00
`define BCS_RST_WORD        16'h0000

`endif

// >>> design/bcs_pkg.sv
package bcs_pkg;

    typedef enum logic [1:0] {
        BCS_ST_IDLE     = 2'b00,
        BCS_ST_FETCH    = 2'b01,
        BCS_ST_READ     = 2'b10,
        BCS_ST_INTERNAL = 2'b11
    } bcs_state_t;

    typedef enum logic [2:0] {
        BCS_MODE_NONE        = 3'b000,
        BCS_MODE_DOWN_ONCE   = 3'b001,
        BCS_MODE_DOWN_REPEAT = 3'b010,
        BCS_MODE_UP_ONCE     = 3'b011,
        BCS_MODE_UP_REPEAT   = 3'b100
    } bcs_mode_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bcs_bus_t;

    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
    } bcs_mem_req_t;

endpackage : bcs_pkg

// >>> design/bcs_search_unit.sv
`timescale 1ns/1ps
`include "bcs_consts.svh"

module bcs_search_unit (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_reset_n,
    input  wire bcs_pkg::bcs_bus_t     i_bus,
    output logic [15:0]                o_rdata,
    output bcs_pkg::bcs_mem_req_t      o_mem_req,
    input  wire logic                  i_mem_ack,
    input  wire logic [7:0]            i_mem_rdata,
    input  wire logic                  i_irq_pending,
    output logic                       o_irq_taken,
    output logic                       o_refresh_slot,
    output logic                       o_busy,
    output logic                       o_done
);
    import bcs_pkg::*;

    // ------------------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------------------
    function automatic bcs_mode_t decode_op(input logic [7:0] prefix,
                                            input logic [7:0] second);
        bcs_mode_t m;
        m = BCS_MODE_NONE;
        if (prefix == `BCS_OP_PREFIX) begin
            unique case (second)
                `BCS_OP_DOWN_ONCE:   m = BCS_MODE_DOWN_ONCE;
                `BCS_OP_DOWN_REPEAT: m = BCS_MODE_DOWN_REPEAT;
                `BCS_OP_UP_ONCE:     m = BCS_MODE_UP_ONCE;
                `BCS_OP_UP_REPEAT:   m = BCS_MODE_UP_REPEAT;
                default:             m = BCS_MODE_NONE;
            endcase
        end
        return m;
    endfunction : decode_op

    function automatic logic is_repeat(input bcs_mode_t m);
        return (m == BCS_MODE_DOWN_REPEAT) || (m == BCS_MODE_UP_REPEAT);
    endfunction : is_repeat

    function automatic logic is_up(input bcs_mode_t m);
        return (m == BCS_MODE_UP_ONCE) || (m == BCS_MODE_UP_REPEAT);
    endfunction : is_up

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    bcs_state_t    state_reg;
    bcs_mode_t     mode_reg;
    logic [3:0]    tcnt_reg;
    logic          last_reg;
    logic          got_reg;
    logic [7:0]    data_reg;
    logic [7:0]    result_reg;
    logic [15:0]   pointer_reg;
    logic [15:0]   counter_reg;
    logic [7:0]    flags_reg;
    logic          done_st_reg;
    logic          intr_st_reg;
    logic          bad_st_reg;
    logic [15:0]   rdata_reg;
    bcs_mem_req_t  mem_req_reg;
    logic          irq_taken_reg;
    logic          refresh_reg;
    logic          done_reg;

    bcs_mode_t     cmd_mode;
    logic          idle;
    logic          cmd_wr;
    logic          start;
    logic          bad_cmd;
    logic [7:0]    mem_byte;
    logic [8:0]    diff;
    logic [4:0]    nib_diff;
    logic          match;
    logic [15:0]   counter_next;
    logic [15:0]   pointer_next;
    logic          last_next;
    logic          read_end;
    logic          int_end;
    logic [3:0]    int_len;
    logic          stop_irq;

    // ------------------------------------------------------------------------
    // Command and compare datapath
    // ------------------------------------------------------------------------
    assign idle     = (state_reg == BCS_ST_IDLE);
    assign cmd_wr   = i_bus.wr && (i_bus.addr == `BCS_OFS_COMMAND);
    assign cmd_mode = decode_op(i_bus.wdata[15:8], i_bus.wdata[7:0]);
    assign start    = cmd_wr && idle && (cmd_mode != BCS_MODE_NONE);
    assign bad_cmd  = cmd_wr && idle && (cmd_mode == BCS_MODE_NONE);

    // Data may arrive during the read phase or exactly on its last state
    assign mem_byte = i_mem_ack ? i_mem_rdata : data_reg;
    // Difference lives only in these nets and is never stored
    assign diff     = {1'b0, result_reg} - {1'b0, mem_byte};
    assign nib_diff = {1'b0, result_reg[3:0]} - {1'b0, mem_byte[3:0]};
    assign match    = (result_reg == mem_byte);
    // Plain wrap: a zero start count becomes all ones, so the scan covers all memory
    assign counter_next = counter_reg - 16'h0001;
    assign pointer_next = is_up(mode_reg) ? pointer_reg + 16'h0001
                                          : pointer_reg - 16'h0001;
    assign last_next    = !is_repeat(mode_reg) || (counter_next == `BCS_RST_WORD)
                          || match;

    assign read_end = (state_reg == BCS_ST_READ) && (got_reg || i_mem_ack)
                      && (tcnt_reg >= (`BCS_READ_T - 4'd1));
    assign int_len  = last_reg ? `BCS_INT_LAST_T : `BCS_INT_CONT_T;
    assign int_end  = (state_reg == BCS_ST_INTERNAL) && (tcnt_reg == (int_len - 4'd1));
    // Irq looked at only after a continuing pass
    assign stop_irq = int_end && !last_reg && i_irq_pending;

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= BCS_ST_IDLE;
            tcnt_reg  <= 4'h0;
        end else begin
            unique case (state_reg)
                BCS_ST_IDLE: begin
                    tcnt_reg <= 4'h0;
                    if (start) begin
                        state_reg <= BCS_ST_FETCH;
                    end
                end
                BCS_ST_FETCH: begin
                    // Two opcode states of three clocks each
                    if (tcnt_reg == (`BCS_FETCH_T - 4'd1)) begin
                        state_reg <= BCS_ST_READ;
                        tcnt_reg  <= 4'h0;
                    end else begin
                        tcnt_reg <= tcnt_reg + 4'h1;
                    end
                end
                BCS_ST_READ: begin
                    // A slow memory stretches this phase; the count then grows
                    // A silent memory stalls it for good
                    if (read_end) begin
                        state_reg <= BCS_ST_INTERNAL;
                        tcnt_reg  <= 4'h0;
                    end else if (tcnt_reg != 4'hf) begin
                        tcnt_reg <= tcnt_reg + 4'h1;
                    end
                end
                BCS_ST_INTERNAL: begin
                    if (int_end) begin
                        tcnt_reg <= 4'h0;
                        if (last_reg || stop_irq) begin
                            state_reg <= BCS_ST_IDLE;
                        end else begin
                            state_reg <= BCS_ST_FETCH;
                        end
                    end else begin
                        tcnt_reg <= tcnt_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_reg <= BCS_MODE_NONE;
        end else if (start) begin
            mode_reg <= cmd_mode;
        end
    end

    // ------------------------------------------------------------------------
    // Memory read: one request per iteration at the unstepped pointer
    // ------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mem_req_reg <= '0;
        end else begin
            // Address held until the next request
            mem_req_reg.rd <= 1'b0;
            if ((state_reg == BCS_ST_FETCH) && (tcnt_reg == (`BCS_FETCH_T - 4'd1))) begin
                mem_req_reg.rd   <= 1'b1;
                mem_req_reg.addr <= pointer_reg;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            got_reg  <= 1'b0;
            data_reg <= `BCS_RST_BYTE;
        end else if (state_reg != BCS_ST_READ) begin
            got_reg <= 1'b0;
        end else if (i_mem_ack && !got_reg) begin
            // First acknowledge of a read wins
            got_reg  <= 1'b1;
            data_reg <= i_mem_rdata;
        end
    end

    // ------------------------------------------------------------------------
    // Pointer and counter
    // ------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pointer_reg <= `BCS_RST_WORD;
        end else if (read_end) begin
            pointer_reg <= pointer_next;
        end else if (i_bus.wr && idle && (i_bus.addr == `BCS_OFS_POINTER)) begin
            pointer_reg <= i_bus.wdata;
        end
    end

    // Updated every iteration so an interrupted search resumes where it left off
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            counter_reg <= `BCS_RST_WORD;
        end else if (read_end) begin
            counter_reg <= counter_next;
        end else if (i_bus.wr && idle && (i_bus.addr == `BCS_OFS_COUNTER)) begin
            counter_reg <= i_bus.wdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            last_reg <= 1'b0;
        end else if (read_end) begin
            last_reg <= last_next;
        end
    end

    // ------------------------------------------------------------------------
    // Accumulator: software only, the search never writes it
    // ------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            result_reg <= `BCS_RST_BYTE;
        end else if (i_bus.wr && idle && (i_bus.addr == `BCS_OFS_RESULT)) begin
            result_reg <= i_bus.wdata[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flags_reg <= `BCS_RST_BYTE;
        end else if (read_end) begin
            flags_reg[`BCS_FLG_NEG]     <= diff[7];
            flags_reg[`BCS_FLG_SUB]     <= 1'b1;
            flags_reg[`BCS_FLG_EQUAL]   <= match;
            flags_reg[`BCS_FLG_NIBBLE]  <= nib_diff[4];
            flags_reg[`BCS_FLG_NONZERO] <= (counter_next != `BCS_RST_WORD);
        end else if (i_bus.wr && idle && (i_bus.addr == `BCS_OFS_FLAGS)) begin
            // Software presets flags only while idle
            flags_reg <= i_bus.wdata[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Status: sticky bits, write one to clear, a new event wins over the clear
    // ------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            done_st_reg <= 1'b0;
            intr_st_reg <= 1'b0;
            bad_st_reg  <= 1'b0;
        end else begin
            if (int_end && last_reg) begin
                done_st_reg <= 1'b1;
            end else if (i_bus.wr && (i_bus.addr == `BCS_OFS_STATUS)
                         && i_bus.wdata[`BCS_ST_DONE]) begin
                done_st_reg <= 1'b0;
            end
            if (stop_irq) begin
                intr_st_reg <= 1'b1;
            end else if ((i_bus.wr && (i_bus.addr == `BCS_OFS_STATUS)
                          && i_bus.wdata[`BCS_ST_INTERRUPTED]) || start) begin
                intr_st_reg <= 1'b0;
            end
            if (bad_cmd) begin
                bad_st_reg <= 1'b1;
            end else if (i_bus.wr && (i_bus.addr == `BCS_OFS_STATUS)
                         && i_bus.wdata[`BCS_ST_BAD_OPCODE]) begin
                bad_st_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Core handshake outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_taken_reg <= 1'b0;
            refresh_reg   <= 1'b0;
            done_reg      <= 1'b0;
        end else begin
            irq_taken_reg <= stop_irq;
            // Offered after each compared byte of a repeat; the core may skip it
            refresh_reg   <= read_end && is_repeat(mode_reg);
            done_reg      <= int_end && last_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Register read port: data valid only in the cycle after the strobe
    // ------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_reg <= `BCS_RST_WORD;
        end else if (i_bus.rd) begin
            unique case (i_bus.addr)
                `BCS_OFS_COMMAND: rdata_reg <= {13'h0000, mode_reg};
                `BCS_OFS_RESULT:  rdata_reg <= {8'h00, result_reg};
                `BCS_OFS_POINTER: rdata_reg <= pointer_reg;
                `BCS_OFS_COUNTER: rdata_reg <= counter_reg;
                `BCS_OFS_FLAGS:   rdata_reg <= {8'h00, flags_reg};
                `BCS_OFS_STATUS:  rdata_reg <= {12'h000, bad_st_reg, intr_st_reg,
                                                done_st_reg, !idle};
                default:          rdata_reg <= `BCS_RST_WORD;
            endcase
        end else begin
            rdata_reg <= `BCS_RST_WORD;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_busy <= 1'b0;
        end else begin
            // Busy falls with the last internal state
            o_busy <= start || (!idle && !(int_end && (last_reg || stop_irq)));
        end
    end

    assign o_rdata        = rdata_reg;
    assign o_mem_req      = mem_req_reg;
    assign o_irq_taken    = irq_taken_reg;
    assign o_refresh_slot = refresh_reg;
    assign o_done         = done_reg;

endmodule : bcs_search_unit

// >>> testbench/bcs_search_monitor.sv
`timescale 1ns/1ps
`include "bcs_consts.svh"
module bcs_search_monitor (
    input wire logic                  i_ref_clk,
    input wire logic                  i_reset_n,
    input wire bcs_pkg::bcs_bus_t     i_bus,
    input wire logic [15:0]           o_rdata,
    input wire bcs_pkg::bcs_mem_req_t o_mem_req,
    input wire logic                  i_mem_ack,
    input wire logic [7:0]            i_mem_rdata,
    input wire logic                  i_irq_pending,
    input wire logic                  o_irq_taken,
    input wire logic                  o_refresh_slot,
    input wire logic                  o_busy,
    input wire logic                  o_done
);
    import bcs_pkg::*;
    // ------------------------------------------------------------------
    // Command decode seen from the bus
    // ------------------------------------------------------------------
    logic cmd_idle;
    logic op_once;
    logic op_ok;
    assign cmd_idle = i_bus.wr && i_bus.addr == `BCS_OFS_COMMAND && !o_busy;
    assign op_once  = i_bus.wdata[7:0] == `BCS_OP_DOWN_ONCE || i_bus.wdata[7:0] == `BCS_OP_UP_ONCE;
    assign op_ok    = i_bus.wdata[15:8] == `BCS_OP_PREFIX && (op_once
                      || i_bus.wdata[7:0] == `BCS_OP_DOWN_REPEAT
                      || i_bus.wdata[7:0] == `BCS_OP_UP_REPEAT);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    busy_start_a: assert property (cmd_idle && op_ok |=> o_busy)
        else $error("valid search command did not start");
    bad_opcode_a: assert property (cmd_idle && !op_ok |=> !o_busy)
        else $error("invalid opcode started a search");
    first_read_a: assert property (cmd_idle && op_ok |-> ##7 o_mem_req.rd)
        else $error("memory read not issued after fetch");
    read_pulse_a: assert property (o_mem_req.rd |=> !o_mem_req.rd)
        else $error("memory read longer than one cycle");
    addr_hold_a: assert property (!o_mem_req.rd |-> $stable(o_mem_req.addr))
        else $error("memory address moved without a read");
    once_time_a: assert property (cmd_idle && op_ok && op_once ##8 i_mem_ack |-> ##5 o_done)
        else $error("single search not finished in twelve states");
    done_pulse_a: assert property (o_done |-> !o_busy ##1 !o_done)
        else $error("done not a single idle pulse");
    rdata_quiet_a: assert property (!$past(i_bus.rd) |-> o_rdata == 16'h0000)
        else $error("read data outside its cycle");
    irq_stop_a: assert property (o_irq_taken |-> !o_done ##1 !o_busy)
        else $error("search kept running after interrupt");
    refresh_busy_a: assert property (o_refresh_slot |-> o_busy)
        else $error("refresh slot outside a search");
endmodule : bcs_search_monitor

// >>> testbench/bcs_mem_model.sv
`timescale 1ns/1ps
module bcs_mem_model (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_reset_n,
    input  wire bcs_pkg::bcs_mem_req_t i_req,
    input  wire logic                  i_slow,
    output logic                       o_ack,
    output logic [7:0]                 o_rdata,
    output int                         o_reads
);
    import bcs_pkg::*;
    // ------------------------------------------------------------------
    // Read-only memory; unwritten bytes read 5a so they never match f3
    // ------------------------------------------------------------------
    logic [7:0]  mem [logic [15:0]];
    logic [15:0] addr_q;
    int          wait_q;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ack   <= 1'b0;
            o_rdata <= 8'h00;
            o_reads <= 0;
            wait_q  <= 0;
            addr_q  <= 16'h0000;
        end else begin
            o_ack   <= 1'b0;
            // Data line is inverted every cycle between answers instead of holding the last byte
            o_rdata <= ~o_rdata;
            if (i_req.rd) begin
                o_reads <= o_reads + 1;
                addr_q  <= i_req.addr;
                wait_q  <= i_slow ? 2 : 0;
                if (!i_slow) begin
                    o_ack   <= 1'b1;
                    o_rdata <= mem.exists(i_req.addr) ? mem[i_req.addr] : 8'h5a;
                end
            end else if (wait_q == 1) begin
                o_ack   <= 1'b1;
                o_rdata <= mem.exists(addr_q) ? mem[addr_q] : 8'h5a;
                wait_q  <= 0;
            end else if (wait_q > 1) begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule : bcs_mem_model

// >>> testbench/tb.sv
`timescale 1ns/1ps
`include "bcs_consts.svh"
module tb;
    import bcs_pkg::*;
    logic         i_ref_clk, i_reset_n, mem_ack, irq_pending, irq_taken;
    logic         refresh_slot, busy, done, slow, rd_d;
    bcs_bus_t     bus;
    bcs_mem_req_t mem_req;
    logic [15:0]  rdata, p, c;
    logic [7:0]   mem_rdata, a8, m;
    logic [15:0]  exp_q [$];
    int           err_total, n_tests, reads, seed, n, refr;

    bcs_search_unit i_dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_bus(bus),
        .o_rdata(rdata), .o_mem_req(mem_req), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
        .i_irq_pending(irq_pending), .o_irq_taken(irq_taken), .o_refresh_slot(refresh_slot),
        .o_busy(busy), .o_done(done));
    bcs_mem_model i_mem (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_req(mem_req),
        .i_slow(slow), .o_ack(mem_ack), .o_rdata(mem_rdata), .o_reads(reads));

    // ------------------------------------------------------------------
    // Bus tasks and checking
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_ref_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_ref_clk) bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge i_ref_clk) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_ref_clk) bus.rd <= 1'b0;
    endtask : rd
    task automatic set(input logic [15:0] pp, cc, aa, ff);
        wr(`BCS_OFS_POINTER, pp);
        wr(`BCS_OFS_COUNTER, cc);
        wr(`BCS_OFS_RESULT, aa);
        wr(`BCS_OFS_FLAGS, ff);
    endtask : set
    task automatic chk(input logic [15:0] pp, cc, aa, ff);
        rd(`BCS_OFS_POINTER, pp);
        rd(`BCS_OFS_COUNTER, cc);
        rd(`BCS_OFS_RESULT, aa);
        rd(`BCS_OFS_FLAGS, ff);
    endtask : chk
    function automatic logic [15:0] flg(input logic [7:0] a, b, input logic [15:0] k,
                                        input logic keep);
        logic [7:0] d;
        d = a - b;
        return {8'h00, d[7], a == b, 1'b0, a[3:0] < b[3:0], 1'b0, k != 16'h0000, 1'b1, keep};
    endfunction : flg
    // Counts edges up to done or an interrupt stop; a hang ends the run
    task automatic run(input logic [7:0] op);
        wr(`BCS_OFS_COMMAND, {`BCS_OP_PREFIX, op});
        for (n = 1; n < 2000; n++) begin
            @(posedge i_ref_clk);
            if (done === 1'b1 || irq_taken === 1'b1) break;
        end
        if (n == 2000) begin
            err_total++;
            print_verdict();
        end
    endtask : run
    task automatic rep_case(input logic [7:0] op, input logic [15:0] pp, cc, st,
                            input int k, input logic hit);
        int         r0, f0;
        logic [7:0] last;
        set(pp, cc, 16'h00f3, 16'h0000);
        for (int j = 0; j < k; j++) i_mem.mem[pp + st * j[15:0]] = 8'h10 + j[7:0];
        last = hit ? 8'hf3 : 8'h22;
        i_mem.mem[pp + st * (k[15:0] - 16'h1)] = last;
        r0 = reads;
        f0 = refr;
        run(op);
        if (slow === 1'b0) check(n[15:0], 16'd14 * (k[15:0] - 16'h1) + 16'd13, "rep_cycles");
        check(reads[15:0] - r0[15:0], k[15:0], "reads");
        check(refr[15:0] - f0[15:0], k[15:0], "refresh");
        chk(pp + st * k[15:0], cc - k[15:0], 16'h00f3, flg(8'hf3, last, cc - k[15:0], 1'b0));
    endtask : rep_case

    always @(posedge i_ref_clk) begin
        if (rd_d) check(rdata, exp_q.pop_front(), "rdata");
        rd_d <= bus.rd;
        if (refresh_slot === 1'b1) refr <= refr + 1;
    end
    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        {i_reset_n, irq_pending, slow, rd_d} = 4'h0;
        bus = '0;
        {err_total, n_tests, seed} = {32'd0, 32'd0, 32'd78};
        repeat (16) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        for (int a = 1; a < 8; a++) rd(a[3:0], 16'h0000);
        set(16'h1111, 16'h0001, 16'h003b, 16'h0001);
        i_mem.mem[16'h1111] = 8'h3b;
        run(`BCS_OP_DOWN_ONCE);
        check(n[15:0], 16'd13, "once_cycles");
        chk(16'h1110, 16'h0000, 16'h003b, 16'h0043);
        for (int i = 0; i < 12; i++) begin
            p = 16'($random(seed));
            c = 16'($random(seed));
            a8 = 8'($random(seed));
            m = (i % 3 == 0) ? a8 : 8'($random(seed));
            slow <= i[0];
            set(p, c, {8'h00, a8}, {15'h0000, i[1]});
            i_mem.mem[p] = m;
            run(i[0] ? `BCS_OP_UP_ONCE : `BCS_OP_DOWN_ONCE);
            chk(i[0] ? p + 16'h1 : p - 16'h1, c - 16'h1, {8'h00, a8}, flg(a8, m, c - 16'h1, i[1]));
        end
        slow <= 1'b0;
        rep_case(`BCS_OP_DOWN_REPEAT, 16'h1118, 16'h0007, 16'hffff, 3, 1'b1);
        rep_case(`BCS_OP_UP_REPEAT, 16'h1111, 16'h0007, 16'h0001, 3, 1'b1);
        rep_case(`BCS_OP_DOWN_REPEAT, 16'h2000, 16'h0002, 16'hffff, 2, 1'b0);
        rep_case(`BCS_OP_UP_REPEAT, 16'h3000, 16'h0000, 16'h0001, 3, 1'b1);
        slow <= 1'b1;
        rep_case(`BCS_OP_UP_REPEAT, 16'h4000, 16'h0004, 16'h0001, 4, 1'b0);
        slow <= 1'b0;
        wr(`BCS_OFS_STATUS, 16'h000e);
        set(16'h5005, 16'h0005, 16'h00f3, 16'h0000);
        irq_pending <= 1'b1;
        run(`BCS_OP_DOWN_REPEAT);
        check({15'h0000, irq_taken}, 16'h0001, "irq_taken");
        irq_pending <= 1'b0;
        rd(`BCS_OFS_STATUS, 16'h0004);
        chk(16'h5004, 16'h0004, 16'h00f3, flg(8'hf3, 8'h5a, 16'h0004, 1'b0));
        run(`BCS_OP_DOWN_REPEAT);
        chk(16'h5000, 16'h0000, 16'h00f3, flg(8'hf3, 8'h5a, 16'h0000, 1'b0));
        wr(`BCS_OFS_STATUS, 16'h000e);
        wr(`BCS_OFS_COMMAND, 16'h12a9);
        rd(`BCS_OFS_STATUS, 16'h0008);
        repeat (4) @(posedge i_ref_clk);
        print_verdict();
    end
endmodule : tb

bind bcs_search_unit bcs_search_monitor i_mon (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_bus(i_bus), .o_rdata(o_rdata), .o_mem_req(o_mem_req), .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata), .i_irq_pending(i_irq_pending), .o_irq_taken(o_irq_taken),
    .o_refresh_slot(o_refresh_slot), .o_busy(o_busy), .o_done(o_done));
